// [logic/rcl_config_top.sv]
// configuration bank of the clock logical device with RAM lock gating
// assumes an APB3 master and a host RAM port, both on clk_sys_in;
// the RAM answers a read in the cycle after ram_rd_out
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/10ps
module rcl_config_top (
    input  wire logic        clk_sys_in,
    input  wire logic        sys_rst_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [11:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    input  wire logic        host_req_in,
    input  wire logic        host_wr_in,
    input  wire logic        host_ext_in,
    input  wire logic [6:0]  host_addr_in,
    input  wire logic [7:0]  host_wdata_in,
    input  wire logic [7:0]  ram_rdata_in,
    output logic             ram_we_out,
    output logic             ram_rd_out,
    output logic             ram_ext_out,
    output logic      [6:0]  ram_addr_out,
    output logic      [7:0]  ram_wdata_out,
    output logic             host_rvalid_out,
    output logic      [7:0]  host_rdata_out,
    output logic             rtc_enable_out,
    output logic      [15:0] base_a_out,
    output logic      [15:0] base_b_out,
    output logic      [7:0]  irq_select_out,
    output logic      [7:0]  irq_type_out,
    output logic      [7:0]  lock_out,
    output logic      [6:0]  date_loc_out,
    output logic      [6:0]  month_loc_out,
    output logic      [6:0]  century_loc_out
);
    typedef struct packed {
        rcl_pkg::rcl_apb_e apb;
        logic              pready;
        logic              pslverr;
        logic [31:0]       prdata;
        logic [7:0]        activate;
        logic [7:0]        base_a_hi;
        logic [7:0]        base_a_lo;
        logic [7:0]        base_b_hi;
        logic [7:0]        base_b_lo;
        logic [7:0]        irq_sel;
        logic [7:0]        irq_type;
        logic [7:0]        lock;
        logic [6:0]        date_loc;
        logic [6:0]        month_loc;
        logic [6:0]        cent_loc;
        logic              ram_we;
        logic              ram_rd;
        logic              ram_ext;
        logic [6:0]        ram_addr;
        logic [7:0]        ram_wdata;
        logic              rd_pend1;
        logic              rd_blk1;
        logic              rd_pend2;
        logic              rd_blk2;
        logic              host_rvalid;
        logic [7:0]        host_rdata;
    } rcl_state_s;

    rcl_state_s cur;
    rcl_state_s next_cur;

    rcl_guard_if g ();

    rcl_ram_guard u_guard (
        .g (g.guard)
    );

    // register index match, used by both read and write decode
    function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
        return a == {2'h0, idx, 2'h0};
    endfunction

    function automatic logic mapped(input logic [11:0] a);
        return hit(a, rcl_pkg::IDX_ACTIVATE)  || hit(a, rcl_pkg::IDX_BASE_A_HI) ||
               hit(a, rcl_pkg::IDX_BASE_A_LO) || hit(a, rcl_pkg::IDX_BASE_B_HI) ||
               hit(a, rcl_pkg::IDX_BASE_B_LO) || hit(a, rcl_pkg::IDX_IRQ_SEL)   ||
               hit(a, rcl_pkg::IDX_IRQ_TYPE)  || hit(a, rcl_pkg::IDX_DMA_A)     ||
               hit(a, rcl_pkg::IDX_DMA_B)     || hit(a, rcl_pkg::IDX_LOCK)      ||
               hit(a, rcl_pkg::IDX_DATE_LOC)  || hit(a, rcl_pkg::IDX_MONTH_LOC) ||
               hit(a, rcl_pkg::IDX_CENT_LOC);
    endfunction

    function automatic logic [7:0] rd_byte(input rcl_state_s s, input logic [11:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (hit(a, rcl_pkg::IDX_ACTIVATE)) begin
            v = s.activate;
        end
        if (hit(a, rcl_pkg::IDX_BASE_A_HI)) begin
            v = s.base_a_hi;
        end
        if (hit(a, rcl_pkg::IDX_BASE_A_LO)) begin
            v = s.base_a_lo & rcl_pkg::BASE_LO_MASK;
        end
        if (hit(a, rcl_pkg::IDX_BASE_B_HI)) begin
            v = s.base_b_hi;
        end
        if (hit(a, rcl_pkg::IDX_BASE_B_LO)) begin
            v = s.base_b_lo & rcl_pkg::BASE_LO_MASK;
        end
        if (hit(a, rcl_pkg::IDX_IRQ_SEL)) begin
            v = s.irq_sel;
        end
        if (hit(a, rcl_pkg::IDX_IRQ_TYPE)) begin
            v = s.irq_type;
        end
        if (hit(a, rcl_pkg::IDX_DMA_A) || hit(a, rcl_pkg::IDX_DMA_B)) begin
            v = rcl_pkg::DMA_NONE;
        end
        if (hit(a, rcl_pkg::IDX_LOCK)) begin
            v = s.lock & rcl_pkg::LOCK_MASK;
        end
        // bit 7 of each locator is reserved and reads zero
        if (hit(a, rcl_pkg::IDX_DATE_LOC)) begin
            v = {1'b0, s.date_loc};
        end
        if (hit(a, rcl_pkg::IDX_MONTH_LOC)) begin
            v = {1'b0, s.month_loc};
        end
        if (hit(a, rcl_pkg::IDX_CENT_LOC)) begin
            v = {1'b0, s.cent_loc};
        end
        return v;
    endfunction

    // guard sees the request in the cycle it arrives
    assign g.active = cur.activate[rcl_pkg::ACT_EN_BIT];
    assign g.lock   = cur.lock;
    assign g.ext    = host_ext_in;
    assign g.addr   = host_addr_in;

    logic [7:0] wb;

    always_comb begin
        next_cur = cur;
        wb       = pwdata_in[7:0];

        // APB slave: answer in the first access cycle
        unique case (cur.apb)
            rcl_pkg::RCL_IDLE: begin
                next_cur.pready  = 1'b0;
                next_cur.pslverr = 1'b0;
                if (psel_in && !penable_in) begin
                    next_cur.apb     = rcl_pkg::RCL_ACK;
                    next_cur.pready  = 1'b1;
                    next_cur.pslverr = !mapped(paddr_in);
                    next_cur.prdata  = {24'h000000, rd_byte(cur, paddr_in)};
                end
            end
            rcl_pkg::RCL_ACK: begin
                next_cur.apb     = rcl_pkg::RCL_IDLE;
                next_cur.pready  = 1'b0;
                next_cur.pslverr = 1'b0;
                // the write lands on the edge where pready is seen high
                if (psel_in && penable_in && pwrite_in) begin
                    if (hit(paddr_in, rcl_pkg::IDX_ACTIVATE)) begin
                        next_cur.activate = wb;
                    end
                    if (hit(paddr_in, rcl_pkg::IDX_BASE_A_HI)) begin
                        next_cur.base_a_hi = wb;
                    end
                    if (hit(paddr_in, rcl_pkg::IDX_BASE_A_LO)) begin
                        next_cur.base_a_lo = wb & rcl_pkg::BASE_LO_MASK;
                    end
                    if (hit(paddr_in, rcl_pkg::IDX_BASE_B_HI)) begin
                        next_cur.base_b_hi = wb;
                    end
                    if (hit(paddr_in, rcl_pkg::IDX_BASE_B_LO)) begin
                        next_cur.base_b_lo = wb & rcl_pkg::BASE_LO_MASK;
                    end
                    if (hit(paddr_in, rcl_pkg::IDX_IRQ_SEL)) begin
                        next_cur.irq_sel = wb;
                    end
                    if (hit(paddr_in, rcl_pkg::IDX_IRQ_TYPE)) begin
                        next_cur.irq_type = (cur.irq_type & ~rcl_pkg::IRQ_TYPE_MASK)
                                          | (wb & rcl_pkg::IRQ_TYPE_MASK);
                    end
                    // ones only ever add; a zero written never clears a lock
                    if (hit(paddr_in, rcl_pkg::IDX_LOCK)) begin
                        next_cur.lock = cur.lock | (wb & rcl_pkg::LOCK_MASK);
                    end
                    if (hit(paddr_in, rcl_pkg::IDX_DATE_LOC)) begin
                        next_cur.date_loc = wb[6:0];
                    end
                    if (hit(paddr_in, rcl_pkg::IDX_MONTH_LOC)) begin
                        next_cur.month_loc = wb[6:0];
                    end
                    if (hit(paddr_in, rcl_pkg::IDX_CENT_LOC)) begin
                        next_cur.cent_loc = wb[6:0];
                    end
                end
            end
            default: begin
                next_cur.apb     = rcl_pkg::RCL_IDLE;
                next_cur.pready  = 1'b0;
                next_cur.pslverr = 1'b0;
            end
        endcase

        // host RAM port: blocked writes never reach the RAM
        next_cur.ram_we    = host_req_in && host_wr_in && g.wr_ok;
        next_cur.ram_rd    = host_req_in && !host_wr_in && !g.rd_blk;
        next_cur.ram_ext   = host_ext_in;
        next_cur.ram_addr  = host_addr_in;
        next_cur.ram_wdata = host_wdata_in;

        // read answer two cycles after the RAM strobe window
        next_cur.rd_pend1    = host_req_in && !host_wr_in;
        next_cur.rd_blk1     = g.rd_blk;
        next_cur.rd_pend2    = cur.rd_pend1;
        next_cur.rd_blk2     = cur.rd_blk1;
        next_cur.host_rvalid = cur.rd_pend2;
        if (cur.rd_pend2) begin
            // masked reads never look at the RAM data
            next_cur.host_rdata = cur.rd_blk2 ? rcl_pkg::BLOCKED_BYTE
                                              : ram_rdata_in;
        end
    end

    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cur.apb         <= rcl_pkg::RCL_IDLE;
            cur.pready      <= 1'b0;
            cur.pslverr     <= 1'b0;
            cur.prdata      <= 32'h00000000;
            cur.activate    <= rcl_pkg::RST_ACTIVATE;
            cur.base_a_hi   <= rcl_pkg::RST_BASE_HI;
            cur.base_a_lo   <= rcl_pkg::RST_BASE_A_LO;
            cur.base_b_hi   <= rcl_pkg::RST_BASE_HI;
            cur.base_b_lo   <= rcl_pkg::RST_BASE_B_LO;
            cur.irq_sel     <= rcl_pkg::RST_IRQ_SEL;
            cur.irq_type    <= rcl_pkg::RST_IRQ_TYPE;
            cur.lock        <= rcl_pkg::RST_LOCK;
            cur.date_loc    <= rcl_pkg::RST_LOCATOR;
            cur.month_loc   <= rcl_pkg::RST_LOCATOR;
            cur.cent_loc    <= rcl_pkg::RST_LOCATOR;
            cur.ram_we      <= 1'b0;
            cur.ram_rd      <= 1'b0;
            cur.ram_ext     <= 1'b0;
            cur.ram_addr    <= 7'h00;
            cur.ram_wdata   <= 8'h00;
            cur.rd_pend1    <= 1'b0;
            cur.rd_blk1     <= 1'b0;
            cur.rd_pend2    <= 1'b0;
            cur.rd_blk2     <= 1'b0;
            cur.host_rvalid <= 1'b0;
            cur.host_rdata  <= 8'h00;
        end else begin
            cur <= next_cur;
        end
    end

    assign prdata_out      = cur.prdata;
    assign pready_out      = cur.pready;
    assign pslverr_out     = cur.pslverr;
    assign ram_we_out      = cur.ram_we;
    assign ram_rd_out      = cur.ram_rd;
    assign ram_ext_out     = cur.ram_ext;
    assign ram_addr_out    = cur.ram_addr;
    assign ram_wdata_out   = cur.ram_wdata;
    assign host_rvalid_out = cur.host_rvalid;
    assign host_rdata_out  = cur.host_rdata;
    assign rtc_enable_out  = cur.activate[rcl_pkg::ACT_EN_BIT];
    assign base_a_out      = {cur.base_a_hi, cur.base_a_lo};
    assign base_b_out      = {cur.base_b_hi, cur.base_b_lo};
    assign irq_select_out  = cur.irq_sel;
    assign irq_type_out    = cur.irq_type;
    assign lock_out        = cur.lock;
    assign date_loc_out    = cur.date_loc;
    assign month_loc_out   = cur.month_loc;
    assign century_loc_out = cur.cent_loc;
endmodule

// [logic/rcl_ram_guard.sv]
// decides per host RAM byte whether a write passes and a read is masked
// assumes lock bits and activate come from registers of the bank
`timescale 1ns/10ps
module rcl_ram_guard (
    rcl_guard_if.guard g
);
    logic ext_low;
    logic std_hi;

    always_comb begin
        ext_low = (g.addr <= rcl_pkg::EXT_LOW_TOP);
        std_hi  = (g.addr >= rcl_pkg::STD_HI_FIRST) && (g.addr <= rcl_pkg::STD_HI_LAST);
        // each blocking bit is and-ed in on its own, so all apply together
        g.wr_ok = g.active && !g.lock[rcl_pkg::LK_ALL_WR];
        g.rd_blk = !g.active;
        if (g.ext) begin
            if (g.lock[rcl_pkg::LK_EXT_ALL]) begin
                g.wr_ok  = 1'b0;
                g.rd_blk = 1'b1;
            end
            if (g.lock[rcl_pkg::LK_EXT_RD] && ext_low) begin
                g.rd_blk = 1'b1;
            end
            if (g.lock[rcl_pkg::LK_EXT_WR] && ext_low) begin
                g.wr_ok = 1'b0;
            end
        end else if (g.lock[rcl_pkg::LK_STD_HI] && std_hi) begin
            g.wr_ok  = 1'b0;
            g.rd_blk = 1'b1;
        end
    end
endmodule

// [shared/rcl_guard_if.sv]
// carrier between the bank and its RAM access guard
// assumes both ends sit on clk_sys_in
`timescale 1ns/10ps
interface rcl_guard_if;
    logic       active;
    logic [7:0] lock;
    logic       ext;
    logic [6:0] addr;
    logic       wr_ok;
    logic       rd_blk;

    modport ctrl  (output active, output lock, output ext, output addr,
                   input wr_ok, input rd_blk);
    modport guard (input active, input lock, input ext, input addr,
                   output wr_ok, output rd_blk);
endinterface

// [shared/rcl_pkg.sv]
// constants, reset values and types for the clock configuration bank
// assumes an APB master on clk_sys_in and a host RAM port on the same clock
// Contract
// - while activate bit 0 is clear the host cannot reach the clock RAM.
// - bit 0 of both low base address bytes always reads zero and ignores writes.
// - reset loads base pair A with 0x0070 and base pair B with 0x0072.
// - the interrupt select register is read/write and resets to 0x08.
// - in the interrupt type register only bit 1 is writable; it resets to zero.
// - both DMA report registers are read-only and always return 0x04.
// - a set lock bit cannot be cleared by software, only by reset.
// - lock bit 3 drops all extended RAM writes and makes its reads return 0xFF.
// - lock bit 4 makes reads of extended bytes 0x00-0x1F return 0xFF.
// - lock bit 5 drops writes to extended bytes 0x00-0x1F.
// - the lock register resets to zero so no lock bit blocks anything after reset.
// - three read/write locator registers at F1, F2, F3 reset to zero.
// - lock bit 7 drops writes to standard bytes 0x38-0x3F and reads them as 0xFF.
// - lock bit 6 drops every write to standard and extended RAM.
package rcl_pkg;
    localparam int APB_AW = 12;

    // register indexes; byte address is four times the index
    localparam logic [7:0] IDX_ACTIVATE  = 8'h30;
    localparam logic [7:0] IDX_BASE_A_HI = 8'h60;
    localparam logic [7:0] IDX_BASE_A_LO = 8'h61;
    localparam logic [7:0] IDX_BASE_B_HI = 8'h62;
    localparam logic [7:0] IDX_BASE_B_LO = 8'h63;
    localparam logic [7:0] IDX_IRQ_SEL   = 8'h70;
    localparam logic [7:0] IDX_IRQ_TYPE  = 8'h71;
    localparam logic [7:0] IDX_DMA_A     = 8'h74;
    localparam logic [7:0] IDX_DMA_B     = 8'h75;
    localparam logic [7:0] IDX_LOCK      = 8'hF0;
    localparam logic [7:0] IDX_DATE_LOC  = 8'hF1;
    localparam logic [7:0] IDX_MONTH_LOC = 8'hF2;
    localparam logic [7:0] IDX_CENT_LOC  = 8'hF3;

    localparam logic [7:0] RST_ACTIVATE  = 8'h00;
    localparam logic [7:0] RST_BASE_HI   = 8'h00;
    localparam logic [7:0] RST_BASE_A_LO = 8'h70;
    localparam logic [7:0] RST_BASE_B_LO = 8'h72;
    localparam logic [7:0] RST_IRQ_SEL   = 8'h08;
    localparam logic [7:0] RST_IRQ_TYPE  = 8'h00;
    localparam logic [7:0] RST_LOCK      = 8'h00;
    localparam logic [6:0] RST_LOCATOR   = 7'h00;
    localparam logic [7:0] DMA_NONE      = 8'h04;

    localparam int         ACT_EN_BIT    = 0;
    localparam logic [7:0] BASE_LO_MASK  = 8'hFE;
    localparam logic [7:0] IRQ_TYPE_MASK = 8'h02;
    localparam logic [7:0] LOCK_MASK     = 8'hF8;
    localparam int         LK_EXT_ALL    = 3;
    localparam int         LK_EXT_RD     = 4;
    localparam int         LK_EXT_WR     = 5;
    localparam int         LK_ALL_WR     = 6;
    localparam int         LK_STD_HI     = 7;
    localparam logic [6:0] EXT_LOW_TOP   = 7'h1F;
    localparam logic [6:0] STD_HI_FIRST  = 7'h38;
    localparam logic [6:0] STD_HI_LAST   = 7'h3F;
    localparam logic [7:0] BLOCKED_BYTE  = 8'hFF;

    typedef enum logic [1:0] {
        RCL_IDLE = 2'h1,
        RCL_ACK  = 2'h2
    } rcl_apb_e;
endpackage

// [verif/rcl_config_monitor.sv]
// concurrent checks on the ports of the clock configuration bank
// assumes one clock domain, bound to rcl_config_top below
`timescale 1ns/10ps
module rcl_config_monitor (
    input wire logic        clk_sys_in,
    input wire logic        sys_rst_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic        pready_out,
    input wire logic        pslverr_out,
    input wire logic        host_req_in,
    input wire logic        host_wr_in,
    input wire logic        host_ext_in,
    input wire logic [6:0]  host_addr_in,
    input wire logic [7:0]  host_wdata_in,
    input wire logic        ram_we_out,
    input wire logic        ram_rd_out,
    input wire logic [6:0]  ram_addr_out,
    input wire logic [7:0]  ram_wdata_out,
    input wire logic        host_rvalid_out,
    input wire logic [7:0]  host_rdata_out,
    input wire logic        rtc_enable_out,
    input wire logic [15:0] base_a_out,
    input wire logic [15:0] base_b_out,
    input wire logic [7:0]  irq_type_out,
    input wire logic [7:0]  lock_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);
    logic [7:0] idx;
    logic       map_ok;
    logic       ext_lo;
    logic       std_hi;
    logic       rd_mask;
    logic       wr_blk;
    assign idx = paddr_in[9:2];
    assign map_ok = paddr_in[1:0] == 2'h0 && paddr_in[11:10] == 2'h0 && idx inside
        {8'h30, 8'h60, 8'h61, 8'h62, 8'h63, 8'h70, 8'h71, 8'h74, 8'h75, [8'hF0:8'hF3]};
    assign ext_lo = host_ext_in && host_addr_in <= 7'h1F;
    assign std_hi = !host_ext_in && host_addr_in >= 7'h38 && host_addr_in <= 7'h3F;
    assign rd_mask = !rtc_enable_out || (host_ext_in && lock_out[3])
        || (ext_lo && lock_out[4]) || (std_hi && lock_out[7]);
    assign wr_blk = !rtc_enable_out || lock_out[6] || (host_ext_in && lock_out[3])
        || (ext_lo && lock_out[5]) || (std_hi && lock_out[7]);

    sequence s_setup;   psel_in && !penable_in;     endsequence
    sequence s_host_rd; host_req_in && !host_wr_in; endsequence
    sequence s_host_wr; host_req_in && host_wr_in;  endsequence

    chk_apb_answer: assert property (s_setup |=> pready_out)
        else $error("no answer in first access cycle");
    chk_unmapped_err: assert property (s_setup ##0 !map_ok |=> pslverr_out && !prdata_out)
        else $error("unmapped access not refused");
    chk_dma_fixed: assert property (
        s_setup ##0 (!pwrite_in && (idx == 8'h74 || idx == 8'h75)) |=> prdata_out == 32'h4)
        else $error("dma report not fixed");
    chk_base_even: assert property (!base_a_out[0] && !base_b_out[0])
        else $error("base address bit 0 set");
    chk_irq_type_ro: assert property ((irq_type_out & 8'hFD) == 8'h00)
        else $error("read-only interrupt type bit set");
    chk_lock_sticky: assert property (##1 (lock_out & $past(lock_out)) == $past(lock_out))
        else $error("lock bit cleared");
    chk_lock_set: assert property (
        s_setup ##0 (pwrite_in && idx == 8'hF0) ##1 pready_out
        |=> lock_out == ($past(lock_out) | ($past(pwdata_in[7:0]) & 8'hF8)))
        else $error("lock write wrong");
    chk_write_pass: assert property (s_host_wr ##0 !wr_blk |=> ram_we_out
        && ram_addr_out == $past(host_addr_in) && ram_wdata_out == $past(host_wdata_in))
        else $error("allowed ram write lost");
    chk_write_drop: assert property (s_host_wr ##0 wr_blk |=> !ram_we_out)
        else $error("blocked ram write passed");
    chk_read_mask: assert property (
        s_host_rd ##0 rd_mask |=> !ram_rd_out ##2 host_rvalid_out && host_rdata_out == 8'hFF)
        else $error("masked read not 0xFF");
    chk_read_pass: assert property (s_host_rd ##0 !rd_mask |=> ram_rd_out ##2 host_rvalid_out)
        else $error("allowed read lost");
endmodule

bind rcl_config_top rcl_config_monitor rcl_config_monitor_inst (
    .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .host_req_in(host_req_in), .host_wr_in(host_wr_in),
    .host_ext_in(host_ext_in), .host_addr_in(host_addr_in), .host_wdata_in(host_wdata_in),
    .ram_we_out(ram_we_out), .ram_rd_out(ram_rd_out), .ram_addr_out(ram_addr_out),
    .ram_wdata_out(ram_wdata_out), .host_rvalid_out(host_rvalid_out),
    .host_rdata_out(host_rdata_out), .rtc_enable_out(rtc_enable_out),
    .base_a_out(base_a_out), .base_b_out(base_b_out), .irq_type_out(irq_type_out),
    .lock_out(lock_out)
);

// [verif/rcl_config_tb_top.sv]
// self-checking bench for the clock configuration bank
// assumes the bank's APB and host ports; the RAM behind it is modelled here
`timescale 1ns/10ps
module rcl_config_tb_top;
    logic        clk_sys_in, sys_rst_in, psel_in, penable_in, pwrite_in, host_req_in;
    logic        host_wr_in, host_ext_in, pready_out, pslverr_out, ram_we_out, ram_rd_out;
    logic        ram_ext_out, host_rvalid_out, rtc_enable_out, act;
    logic [11:0] paddr_in;
    logic [31:0] pwdata_in, prdata_out;
    logic [6:0]  host_addr_in, ram_addr_out, date_loc_out, month_loc_out, century_loc_out;
    logic [7:0]  host_wdata_in, ram_rdata_in, ram_wdata_out, host_rdata_out, lk;
    logic [7:0]  irq_select_out, irq_type_out, lock_out, mem[256], sh[256];
    logic [15:0] base_a_out, base_b_out;
    logic [39:0] qa[$], qh[$], qw[$];
    int          num_errors = 0;
    int          n_compared = 0;

    rcl_config_top rcl_config_top_inst (
        .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .psel_in(psel_in),
        .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
        .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
        .pslverr_out(pslverr_out), .host_req_in(host_req_in), .host_wr_in(host_wr_in),
        .host_ext_in(host_ext_in), .host_addr_in(host_addr_in), .host_wdata_in(host_wdata_in),
        .ram_rdata_in(ram_rdata_in), .ram_we_out(ram_we_out), .ram_rd_out(ram_rd_out),
        .ram_ext_out(ram_ext_out), .ram_addr_out(ram_addr_out), .ram_wdata_out(ram_wdata_out),
        .host_rvalid_out(host_rvalid_out), .host_rdata_out(host_rdata_out),
        .rtc_enable_out(rtc_enable_out), .base_a_out(base_a_out), .base_b_out(base_b_out),
        .irq_select_out(irq_select_out), .irq_type_out(irq_type_out), .lock_out(lock_out),
        .date_loc_out(date_loc_out), .month_loc_out(month_loc_out),
        .century_loc_out(century_loc_out)
    );

    always #20 clk_sys_in = ~clk_sys_in;

    // ram model: data toggles outside reads so stale data cannot pass
    always @(posedge clk_sys_in) begin
        if (ram_we_out) mem[{ram_ext_out, ram_addr_out}] <= ram_wdata_out;
        ram_rdata_in <= ram_rd_out ? mem[{ram_ext_out, ram_addr_out}] : ~ram_rdata_in;
    end

    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask

    always @(posedge clk_sys_in) begin
        if (pready_out && psel_in && !pwrite_in)
            check({7'h0, pslverr_out, prdata_out}, qa.pop_front());
        if (host_rvalid_out) check({32'h0, host_rdata_out}, qh.pop_front());
        if (ram_we_out)
            check({24'h0, ram_ext_out, ram_addr_out, ram_wdata_out}, qw.pop_front());
    end

    task automatic print_verdict;
        if (qa.size() + qh.size() + qw.size() != 0) num_errors++;
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d,
                       input logic err = 1'b0);
        int w;
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= wr;
        paddr_in <= {2'h0, idx, 2'h0};
        pwdata_in <= {24'($urandom()), d};
        if (!wr) qa.push_back({7'h0, err, 24'h0, d});
        if (wr && idx == rcl_pkg::IDX_LOCK) lk = lk | (d & rcl_pkg::LOCK_MASK);
        if (wr && idx == rcl_pkg::IDX_ACTIVATE) act = d[0];
        @(posedge clk_sys_in);
        penable_in <= 1'b1;
        w = 0;
        do begin @(posedge clk_sys_in); w++; end while (pready_out !== 1'b1 && w < 20);
        if (w == 20) num_errors++;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        @(posedge clk_sys_in);
    endtask

    // request stays raised between calls; sweep lowers it
    task automatic host(input logic wr, input logic ext, input logic [6:0] a,
                        input logic [7:0] d);
        logic hi, lo;
        hi = !ext && a >= 7'h38 && a <= 7'h3F;
        lo = ext && a <= 7'h1F;
        host_req_in <= 1'b1;
        host_wr_in <= wr;
        host_ext_in <= ext;
        host_addr_in <= a;
        host_wdata_in <= d;
        if (wr && !(!act || lk[6] || (ext && lk[3]) || (lo && lk[5]) || (hi && lk[7]))) begin
            sh[{ext, a}] = d;
            qw.push_back({24'h0, ext, a, d});
        end
        if (!wr) qh.push_back((!act || (ext && lk[3]) || (lo && lk[4]) || (hi && lk[7]))
                              ? 40'hFF : {32'h0, sh[{ext, a}]});
        @(posedge clk_sys_in);
    endtask

    task automatic sweep;
        logic [6:0] at[7];
        at = '{7'h00, 7'h1F, 7'h20, 7'h38, 7'h3F, 7'h40, 7'h7F};
        for (int i = 0; i < 14; i++) begin
            host(1'b1, i[0], at[i / 2], 8'($urandom()));
            host(1'b0, i[0], at[i / 2], 8'h00);
        end
        host_req_in <= 1'b0;
        repeat (4) @(posedge clk_sys_in);
    endtask

    initial begin
        #800000;
        num_errors++;
        print_verdict();
    end

    initial begin
        logic [15:0] rv[13];
        logic [23:0] wt[11];
        logic [7:0]  stg[6];
        logic [7:0]  r;
        logic [87:0] ex;
        rv = '{16'h3000, 16'h6000, 16'h6170, 16'h6200, 16'h6372, 16'h7008, 16'h7100,
               16'h7404, 16'h7504, 16'hF000, 16'hF100, 16'hF200, 16'hF300};
        wt = '{24'h60FF00, 24'h61FE00, 24'h62FF00, 24'h63FE00, 24'h70FF00, 24'h710200,
               24'h740004, 24'h750004, 24'hF17F00, 24'hF27F00, 24'hF37F00};
        stg = '{8'h00, 8'h10, 8'h20, 8'h08, 8'h80, 8'h40};
        {clk_sys_in, sys_rst_in, psel_in, penable_in, pwrite_in, host_req_in} = 6'h10;
        {host_wr_in, host_ext_in, host_addr_in, host_wdata_in, paddr_in, pwdata_in} = '0;
        ram_rdata_in = 8'h00;
        lk = 8'h00;
        act = 1'b0;
        for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'hA5;
        sh = mem;
        void'($urandom(50097));
        repeat (4) @(posedge clk_sys_in);
        sys_rst_in <= 1'b0;
        @(posedge clk_sys_in);
        foreach (rv[i]) apb(1'b0, rv[i][15:8], rv[i][7:0]);
        apb(1'b0, 8'h31, 8'h00, 1'b1);
        $display("test reset values done");
        foreach (wt[i]) begin
            r = 8'($urandom());
            apb(1'b1, wt[i][23:16], r);
            ex = {ex[79:0], (r & wt[i][15:8]) | wt[i][7:0]};
            apb(1'b0, wt[i][23:16], ex[7:0]);
        end
        check({base_a_out, base_b_out, irq_select_out}, ex[87:48]);
        check({16'h0404, 1'b0, date_loc_out, 1'b0, month_loc_out, 1'b0,
               century_loc_out}, ex[39:0]);
        apb(1'b1, 8'h31, 8'hFF, 1'b1);
        $display("test register access done");
        sweep();
        apb(1'b1, rcl_pkg::IDX_ACTIVATE, 8'h01);
        for (int s = 0; s < 6; s++) begin
            apb(1'b1, rcl_pkg::IDX_LOCK, stg[s] | 8'($urandom() & 7));
            apb(1'b0, rcl_pkg::IDX_LOCK, lk);
            sweep();
        end
        apb(1'b1, rcl_pkg::IDX_LOCK, 8'h00);
        apb(1'b0, rcl_pkg::IDX_LOCK, lk);
        $display("test ram locking done");
        sys_rst_in <= 1'b1;
        repeat (2) @(posedge clk_sys_in);
        sys_rst_in <= 1'b0;
        lk = 8'h00;
        act = 1'b0;
        @(posedge clk_sys_in);
        apb(1'b0, rcl_pkg::IDX_LOCK, 8'h00);
        apb(1'b0, rcl_pkg::IDX_ACTIVATE, 8'h00);
        sweep();
        $display("test second reset done");
        repeat (4) @(posedge clk_sys_in);
        print_verdict();
    end
endmodule
